//--- core/spe_pkg.sv
// shared constants for the paged serial eeprom slave
package spe_pkg;
	// array geometry
	localparam int PAGE_BYTES = 16;
	localparam int PAGE_OFS_W = 4;
	localparam int SIZE_KB_DEF = 16;
	localparam int BYTES_PER_KB = 128;
	localparam logic [3:0] SEL_PATTERN = 4'b1010;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	// timing, figures in their own units
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_FREQ_KHZ = 100000;
	localparam int T_PROG_MS = 4;
	localparam int T_PU_US = 350;
	localparam int T_NOISE_NS = 50;
	localparam int SCL_STD_KHZ = 100;
	localparam int SCL_FAST_KHZ = 400;
	// longest times round down, filter window is the noise width in clocks
	localparam int PROG_CYCLES = T_PROG_MS * CLK_FREQ_KHZ;
	localparam int PU_CYCLES = (T_PU_US * CLK_FREQ_KHZ) / 1000;
	localparam int NOISE_CYCLES = T_NOISE_NS / CLK_PERIOD_NS;
	// shortest scl half period at fast rate, in clocks
	localparam int FAST_HALF_CYCLES = CLK_FREQ_KHZ / (2 * SCL_FAST_KHZ);
	// transaction phases
	localparam logic [1:0] PH_DEV = 2'h0;
	localparam logic [1:0] PH_WADDR = 2'h1;
	localparam logic [1:0] PH_DATA = 2'h2;
endpackage

//--- core/spe_deglitch.sv
// two-flop synchroniser and noise filter for one bus line
`timescale 1ns/1ps
module spe_deglitch #(
	parameter int FILT_CYCLES = spe_pkg::NOISE_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// line
	input wire logic line_i,
	output logic line_o
);
	import spe_pkg::*;

	localparam int CW = $clog2(FILT_CYCLES + 2);
	localparam logic [CW-1:0] CNT_LAST = CW'(FILT_CYCLES);

	typedef struct packed {
		logic s1;
		logic s2;
		logic [CW-1:0] cnt;
		logic out;
	} spe_dg_t;

	spe_dg_t st_r, st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = line_i;
		st_nxt.s2 = st_r.s1;
		if (st_r.s2 == st_r.out) begin
			st_nxt.cnt = '0;
		end else if (st_r.cnt == CNT_LAST) begin
			// level held longer than the noise window
			st_nxt.out = st_r.s2;
			st_nxt.cnt = '0;
		end else begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_r <= '{s1: 1'b1, s2: 1'b1, cnt: '0, out: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign line_o = st_r.out;
endmodule

//--- core/spe_eeprom.sv
// two-wire paged eeprom slave: protocol engine, page buffer and array
`timescale 1ns/1ps
//
// Contract
// - array is 16 to 128 pages of sixteen bytes, by size.
// - write takes a start location plus one to sixteen bytes, committed at once.
// - read shifts out bytes and advances the location after each.
// - select pins share the bus among eight, four, two or one parts.
// - program cycle, byte or page, ends within 4 ms.
// - no commands accepted until 0.35 ms after power is stable.
// - serial clock up to 100 kHz standard, 400 kHz fast.
// - undriven select and write-inhibit inputs count as low; the inputs have no pull-downs, undriven ones float.
// - pulses of 50 ns or less on clock and data are ignored.
// - write inhibit protects the whole array.
// - one program operation is one write cycle, byte or page.
// - selection byte is 1010, three select or high bits, then read bit.
// - page load steps only the low four location bits, wrapping.
// - no acknowledge to a selection byte while programming.
// - write inhibit sampled before first data byte; high refuses and discards.
module spe_eeprom #(
	parameter int SIZE_KB = spe_pkg::SIZE_KB_DEF,
	parameter int PROG_CYCLES = spe_pkg::PROG_CYCLES,
	parameter int PU_CYCLES = spe_pkg::PU_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// two-wire bus
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// straps
	input wire logic select_pin_low_i,
	input wire logic select_pin_mid_i,
	input wire logic select_pin_high_i,
	input wire logic write_inhibit_i,
	// status
	output logic ready_o,
	output logic busy_o
);
	import spe_pkg::*;

	localparam int HI_BITS = $clog2(SIZE_KB / 2);
	localparam int AW = 8 + HI_BITS;
	localparam int MEM_BYTES = SIZE_KB * BYTES_PER_KB;
	localparam int PW = $clog2(PROG_CYCLES + 1);
	localparam int UW = $clog2(PU_CYCLES + 1);
	localparam logic [PW-1:0] PROG_LAST = PW'(PROG_CYCLES - 1);
	localparam logic [UW-1:0] PU_LAST = UW'(PU_CYCLES - 1);

	typedef enum logic [5:0] {
		S_IDLE = 6'b00_0001,
		S_RX = 6'b00_0010,
		S_ACK = 6'b00_0100,
		S_TX = 6'b00_1000,
		S_MACK = 6'b01_0000,
		S_WAIT = 6'b10_0000
	} spe_state_t;

	typedef struct packed {
		spe_state_t state;
		logic [1:0] phase;
		logic [3:0] bitcnt;
		logic [7:0] sh;
		logic [AW-1:0] addr;
		logic rd;
		logic first_pend;
		logic wp_lat;
		logic mack_ok;
		logic [PAGE_BYTES-1:0] loaded;
		logic oe;
		logic busy;
		logic [PW-1:0] prog_cnt;
		logic ready;
		logic [UW-1:0] pu_cnt;
		logic scl_d;
		logic sda_d;
		logic [3:0] pin_s1;
		logic [3:0] pin_s2;
	} spe_st_t;

	spe_st_t st_r, st_nxt;
	logic [7:0] mem [MEM_BYTES];
	logic [7:0] pbuf [PAGE_BYTES];
	logic [1:0] raw_lines;
	logic [1:0] flt_lines;
	logic scl_f, sda_f;
	logic scl_rise, scl_fall, start_ev, stop_ev;
	logic buf_we;
	logic commit;
	logic [3:0] pins;
	logic sel_match;

	// clock and data through the noise filter
	assign raw_lines = {scl_i, sda_i};
	for (genvar g = 0; g < 2; g++) begin : g_flt
		spe_deglitch #(.FILT_CYCLES(NOISE_CYCLES)) u_flt (
			.clk_i(clk_i),
			.srst_i(srst_i),
			.line_i(raw_lines[g]),
			.line_o(flt_lines[g])
		);
	end
	assign scl_f = flt_lines[1];
	assign sda_f = flt_lines[0];
	// edges found by oversampling; 400 kHz leaves FAST_HALF_CYCLES per phase
	assign scl_rise = scl_f & ~st_r.scl_d;
	assign scl_fall = ~scl_f & st_r.scl_d;
	assign start_ev = scl_f & st_r.scl_d & st_r.sda_d & ~sda_f;
	assign stop_ev = scl_f & st_r.scl_d & ~st_r.sda_d & sda_f;

	// pins: {inhibit, high, mid, low}; taken after two synchroniser flops, no pull-downs here
	assign pins = st_r.pin_s2;

	// upper select bits compare to pins, lower ones carry array address
	always_comb begin
		sel_match = (st_r.sh[7:4] == SEL_PATTERN);
		for (int i = HI_BITS; i < 3; i++) begin
			if (st_r.sh[i+1] != pins[i]) begin
				sel_match = 1'b0;
			end
		end
	end

	assign commit = st_r.busy && (st_r.prog_cnt == '0);

	always_comb begin
		st_nxt = st_r;
		buf_we = 1'b0;
		st_nxt.scl_d = scl_f;
		st_nxt.sda_d = sda_f;
		st_nxt.pin_s1 = {write_inhibit_i, select_pin_high_i, select_pin_mid_i,
			select_pin_low_i};
		st_nxt.pin_s2 = st_r.pin_s1;
		if (!st_r.ready) begin
			if (st_r.pu_cnt == PU_LAST) begin
				st_nxt.ready = 1'b1;
			end else begin
				st_nxt.pu_cnt = st_r.pu_cnt + 1'b1;
			end
		end
		if (st_r.busy) begin
			if (commit) begin
				st_nxt.busy = 1'b0;
				st_nxt.loaded = '0;
			end else begin
				st_nxt.prog_cnt = st_r.prog_cnt - 1'b1;
			end
		end
		if (!st_r.ready) begin
			st_nxt.state = S_IDLE;
		end else if (start_ev) begin
			st_nxt.state = S_RX;
			st_nxt.phase = PH_DEV;
			st_nxt.bitcnt = '0;
			st_nxt.oe = 1'b0;
		end else if (stop_ev) begin
			st_nxt.state = S_IDLE;
			st_nxt.oe = 1'b0;
			// one program cycle for the whole loaded page
			if (st_r.phase == PH_DATA && !st_r.rd && !st_r.wp_lat && |st_r.loaded
				&& !st_r.busy) begin
				st_nxt.busy = 1'b1;
				st_nxt.prog_cnt = PROG_LAST;
			end else begin
				// keep a commit's clear when stop and commit coincide
				st_nxt.loaded = st_r.busy ? st_nxt.loaded : '0;
			end
			st_nxt.phase = PH_DEV;
		end else begin
			case (st_r.state)
				S_IDLE, S_WAIT: begin
					st_nxt.oe = 1'b0;
				end
				S_RX: begin
					if (scl_rise && st_r.bitcnt != 4'h8) begin
						st_nxt.sh = {st_r.sh[6:0], sda_f};
						st_nxt.bitcnt = st_r.bitcnt + 1'b1;
					end else if (scl_fall && st_r.bitcnt == 4'h8) begin
						st_nxt.state = S_ACK;
						st_nxt.oe = 1'b1;
						case (st_r.phase)
							PH_DEV: begin
								if (!sel_match || st_r.busy) begin
									st_nxt.state = S_WAIT;
									st_nxt.oe = 1'b0;
								end else begin
									st_nxt.rd = st_r.sh[0];
									for (int i = 0; i < HI_BITS; i++) begin
										st_nxt.addr[8+i] = st_r.sh[i+1];
									end
									st_nxt.phase = PH_WADDR;
								end
							end
							PH_WADDR: begin
								st_nxt.addr[7:0] = st_r.sh;
								st_nxt.phase = PH_DATA;
								st_nxt.first_pend = 1'b1;
								st_nxt.loaded = '0;
							end
							default: begin
								if (st_r.wp_lat) begin
									st_nxt.state = S_WAIT;
									st_nxt.oe = 1'b0;
									st_nxt.loaded = '0;
								end else begin
									buf_we = 1'b1;
									st_nxt.loaded[st_r.addr[3:0]] = 1'b1;
									st_nxt.addr[3:0] = st_r.addr[3:0] + 1'b1;
								end
							end
						endcase
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						st_nxt.oe = 1'b0;
						st_nxt.bitcnt = '0;
						st_nxt.state = S_RX;
						if (st_r.first_pend) begin
							st_nxt.wp_lat = pins[3];
							st_nxt.first_pend = 1'b0;
						end
						if (st_r.phase == PH_WADDR && st_r.rd) begin
							st_nxt.state = S_TX;
							st_nxt.sh = {mem[st_r.addr][6:0], 1'b0};
							st_nxt.oe = ~mem[st_r.addr][7];
							st_nxt.bitcnt = 4'h1;
							st_nxt.addr = st_r.addr + 1'b1;
						end
					end
				end
				S_TX: begin
					if (scl_fall) begin
						if (st_r.bitcnt == 4'h8) begin
							st_nxt.oe = 1'b0;
							st_nxt.state = S_MACK;
						end else begin
							st_nxt.oe = ~st_r.sh[7];
							st_nxt.sh = {st_r.sh[6:0], 1'b0};
							st_nxt.bitcnt = st_r.bitcnt + 1'b1;
						end
					end
				end
				S_MACK: begin
					if (scl_rise) begin
						st_nxt.mack_ok = ~sda_f;
					end else if (scl_fall) begin
						if (st_r.mack_ok) begin
							st_nxt.state = S_TX;
							st_nxt.sh = {mem[st_r.addr][6:0], 1'b0};
							st_nxt.oe = ~mem[st_r.addr][7];
							st_nxt.bitcnt = 4'h1;
							st_nxt.addr = st_r.addr + 1'b1;
						end else begin
							st_nxt.state = S_WAIT;
						end
					end
				end
				default: begin
					st_nxt.state = S_IDLE;
					st_nxt.oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_r <= '0;
			st_r.state <= S_IDLE;
			st_r.phase <= PH_DEV;
			st_r.scl_d <= 1'b1;
			st_r.sda_d <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// page buffer and array; the array powers up erased
	always_ff @(posedge clk_i) begin
		if (buf_we) begin
			pbuf[st_r.addr[3:0]] <= st_r.sh;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			for (int i = 0; i < MEM_BYTES; i++) begin
				mem[i] <= ERASED_BYTE;
			end
		end else if (commit) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (st_r.loaded[i]) begin
					mem[{st_r.addr[AW-1:PAGE_OFS_W], PAGE_OFS_W'(i)}] <= pbuf[i];
				end
			end
		end
	end

	assign sda_o = 1'b0;
	assign sda_oe_o = st_r.oe;
	assign ready_o = st_r.ready;
	assign busy_o = st_r.busy;
endmodule

//--- verif/spe_monitor.sv
// port checker for the paged eeprom slave
`timescale 1ns/1ps
module spe_monitor #(
	parameter int PROG_CYCLES = 400000,
	parameter int PU_CYCLES = 35000
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// bus and straps
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic write_inhibit_i,
	// device outputs
	input wire logic sda_oe_o,
	input wire logic ready_o,
	input wire logic busy_o
);
	int pu_cnt;
	int busy_cnt;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	always_ff @(posedge clk_i) begin
		pu_cnt <= srst_i ? 0 : pu_cnt + ((pu_cnt < PU_CYCLES + 4) ? 1 : 0);
		busy_cnt <= (srst_i || !busy_o) ? 0 : busy_cnt + 1;
	end
	a_reset_quiet: assert property ($fell(srst_i) |->
		!ready_o && !busy_o && !sda_oe_o)
		else $error("outputs active right after reset");
	a_ready_early: assert property (ready_o |-> pu_cnt >= PU_CYCLES - 1)
		else $error("ready before power-up delay");
	a_ready_late: assert property (pu_cnt >= PU_CYCLES + 2 |-> ready_o)
		else $error("ready missing after power-up delay");
	a_idle_silent: assert property (!ready_o |-> !busy_o && !sda_oe_o)
		else $error("activity before ready");
	a_prog_bound: assert property (busy_o |-> busy_cnt <= PROG_CYCLES + 1)
		else $error("program cycle too long");
	a_prog_whole: assert property ($fell(busy_o) |-> busy_cnt >= PROG_CYCLES)
		else $error("program cycle cut short");
	a_busy_deaf: assert property (busy_o && $past(busy_o) |-> !sda_oe_o)
		else $error("data line driven while programming");
	a_out_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("data output changed with clock high");
	a_prog_after_stop: assert property ($rose(busy_o) |->
		scl_i && sda_i && !write_inhibit_i)
		else $error("program started without stop or while inhibited");
endmodule

bind spe_eeprom spe_monitor #(.PROG_CYCLES(PROG_CYCLES), .PU_CYCLES(PU_CYCLES)) mon (
	.clk_i(clk_i), .srst_i(srst_i), .scl_i(scl_i), .sda_i(sda_i),
	.write_inhibit_i(write_inhibit_i), .sda_oe_o(sda_oe_o), .ready_o(ready_o), .busy_o(busy_o));

//--- verif/spe_tb_master.sv
// two-wire bus master model, open drain data
`timescale 1ns/1ps
module spe_tb_master (
	// clock
	input wire logic clk_i,
	// bus
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	logic glitch = 0;
	initial begin
		scl_o = 1;
		sda_o = 1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// also serves as repeated start from clock low
	task automatic start();
		sda_o = 1;
		tick(6);
		scl_o = 1;
		tick(12);
		sda_o = 0;
		tick(12);
		scl_o = 0;
		tick(6);
	endtask
	task automatic stop();
		sda_o = 0;
		tick(6);
		scl_o = 1;
		tick(12);
		sda_o = 1;
		tick(24);
	endtask
	task automatic bit_x(input logic b, output logic r);
		sda_o = b;
		if (glitch) begin
			scl_o = 1;
			tick(3);
			scl_o = 0;
			glitch = 0;
		end
		tick(12);
		scl_o = 1;
		tick(6);
		r = sda_i;
		tick(6);
		scl_o = 0;
		tick(6);
	endtask
	task automatic xfer(input logic [7:0] d, input logic ack_m, output logic [7:0] q,
		output logic ack_s);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
		bit_x(ack_m, ack_s);
	endtask
endmodule

//--- verif/tb.sv
// self-checking bench for the paged eeprom slave
`timescale 1ns/1ps
module tb;
	import spe_pkg::*;
	logic clk_i = 0;
	logic srst_i = 1;
	logic wp = 0;
	logic [2:0] strap = 3'h0;
	logic sda_oe_o, sda_dout, ready_o, busy_o, mscl, msda, ak;
	logic [7:0] a, q;
	logic [7:0] mem [256];
	logic [31:0] rs = 32'h5b36_8098;
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;
	// open-drain bus: the device's data level counts only while it drives
	wire sda_w = sda_oe_o ? (msda & sda_dout) : msda;
	spe_eeprom #(.SIZE_KB(2), .PROG_CYCLES(1000), .PU_CYCLES(20)) uut (.clk_i(clk_i),
		.srst_i(srst_i), .scl_i(mscl), .sda_i(sda_w), .sda_o(sda_dout), .sda_oe_o(sda_oe_o),
		.select_pin_low_i(strap[0]), .select_pin_mid_i(strap[1]), .select_pin_high_i(strap[2]),
		.write_inhibit_i(wp), .ready_o(ready_o), .busy_o(busy_o));
	spe_tb_master m (.clk_i(clk_i), .sda_i(sda_w), .scl_o(mscl), .sda_o(msda));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	function automatic logic [7:0] loc(input logic [7:0] b, input int i);
		return {b[7:4], b[3:0] + 4'(i)};
	endfunction
	task automatic summarize();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk({7'h0, got}, {7'h0, exp});
	endtask
	task automatic sel(input logic rw, input logic [2:0] s);
		m.start();
		m.xfer({4'ha, s, rw}, 1'b1, q, ak);
	endtask
	task automatic set_addr(input logic [7:0] b);
		sel(0, strap);
		chk_bit(ak, 0);
		m.xfer(b, 1, q, ak);
		chk_bit(ak, 0);
	endtask
	task automatic write_run(input logic [7:0] b, input int n);
		logic [7:0] d;
		set_addr(b);
		for (int i = 0; i < n; i++) begin
			d = 8'(xs());
			mem[loc(b, i)] = d;
			m.xfer(d, 1, q, ak);
			chk_bit(ak, 0);
		end
		m.stop();
		sel(0, strap);
		chk_bit(ak, 1);
		m.stop();
		for (int k = 0; k < 1500 && busy_o !== 0; k++) @(negedge clk_i);
		chk_bit(busy_o, 0);
	endtask
	task automatic read_run(input logic [7:0] b, input int n);
		set_addr(b);
		sel(1, strap);
		chk_bit(ak, 0);
		for (int i = 0; i < n; i++) begin
			m.xfer(8'hff, i == n - 1, q, ak);
			chk(q, mem[8'(b + i)]);
		end
		m.stop();
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			summarize();
		end
	end
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
		strap = 3'(xs());
		a = 8'(xs());
		repeat (4) @(negedge clk_i);
		srst_i = 0;
		for (int k = 0; k < 100 && ready_o !== 1; k++) @(negedge clk_i);
		chk_bit(ready_o, 1);
		sel(0, strap ^ 3'h1);
		chk_bit(ak, 1);
		m.stop();
		write_run({a[7:4], 4'he}, 18);
		write_run(8'(xs()), 1);
		read_run({a[7:4], 4'h0}, 16);
		read_run(8'hfe, 3);
		// current-address read: counter stands at 8'h01 after the wrap above
		sel(1, strap);
		chk_bit(ak, 0);
		m.xfer(8'hff, 1, q, ak);
		chk(q, mem[8'h01]);
		m.stop();
		wp = 1;
		set_addr(a);
		m.xfer(8'h5a, 1, q, ak);
		chk_bit(ak, 1);
		m.stop();
		m.tick(20);
		chk_bit(busy_o, 0);
		wp = 0;
		read_run({a[7:4], 4'h0}, 16);
		m.glitch = 1;
		sel(0, strap);
		chk_bit(ak, 0);
		m.stop();
		summarize();
	end
endmodule
